// file: logic/pbcc_top.sv
// Calendar clock core with asynchronous 8-bit register port and open-drain pulse pin
//
// Behaviour
// - Access only while active-low select is low and active-high select high.
// - Write strobe rising edge stores data bus into the addressed register.
// - Read strobe drives addressed register onto bus, released at its rising edge.
// - Hour bit 7 selects format: 0 is 24-hour, 1 is 12-hour.
// - Hour bit 6 marks PM in 12-hour mode, always 0 in 24-hour.
// - Leap control upper bit disables leap years, lower bit enables counter writes.
// - Leap handling on and leap counter 00 gives February 29 days.
// - Leap control 10 always goes from February 28 to March 1.
// - Modes 0 to 3 give square waves of 2048, 1024, 256, 64 Hz.
// - Modes 4 to 10 give interval signals from 1/2048 s to 60 s.
// - Mode 11 shows the busy condition on the pulse pin.
// - Pin enable bit 1 floats the pulse pin; 0 keeps it active.
// - Disabling the pin leaves the pin-state flag showing internal state.
// - Control read: bit3 don't care, bit2 pin state, bit1 oscillation, bit0 busy.
// - Oscillation flag latches 0; only a clock reset while running sets it.
// - Oscillation flag is 0 after first power.
// - Busy flag is 1 while the time counter updates.
// - Every BCD digit counts within its documented range.
// - Hour encoding: 24-hour plain BCD, 12-hour with format and PM bits.
`default_nettype none
`include "pbcc_params.svh"
module pbcc_top
  import pbcc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic select_active_low_n_i,
  input wire logic select_active_high_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic osc_running_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  output logic pulse_pin_o,
  output logic pulse_pin_oe_n_o
);
  logic [15:0] pins_w;
  logic [15:0] sync1_r;
  logic [15:0] sync2_r;
  logic osc_s, csn_s, cs_s, wrn_s, rdn_s;
  logic [2:0] addr_s;
  logic [7:0] data_s;
  logic wr_prev_r, sel_w, wr_evt, ctl_wr, clk_grp, out_grp;
  logic clk_rst_cmd, adj_cmd, int_rst_cmd;
  pbcc_bcd_t sec_r, min_r, hour_r, day_r, mon_r, year_r, hour_inc_w;
  logic [1:0] leap_ctrl_r, leap_cnt_r;
  logic [3:0] dow_r, mode_r;
  logic clk_stop_r, pin_dis_r, int_stop_r, oscillation_flag_r, pin_flag_r, pin_flag_nxt;
  logic [14:0] presc_r;
  logic [20:0] int_cnt_r, int_per_w;
  logic tick, sec_tick, busy_w, leap_w;
  logic c_min, c_hour, c_day, c_mon, c_year;
  logic [7:0] data_r;
  logic oe_n_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  function automatic pbcc_bcd_t bcd_inc(input pbcc_bcd_t v);
    if (v == 8'h99)
      return 8'h00;
    else if (v[3:0] == 4'h9)
      return {v[7:4] + 4'h1, 4'h0};
    else
      return {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic pbcc_bcd_t month_days(input pbcc_bcd_t m, input logic leap);
    case (m)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : month_days

  // All pins cross from the host's timing into ours through two stages
  assign pins_w = {osc_running_i, select_active_low_n_i, select_active_high_i, wr_n_i, rd_n_i, addr_i, data_i};
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_r <= 16'h7800;
      sync2_r <= 16'h7800;
      wr_prev_r <= 1'b1;
    end
    else
    begin
      sync1_r <= pins_w;
      sync2_r <= sync1_r;
      wr_prev_r <= wrn_s;
    end
  end
  assign {osc_s, csn_s, cs_s, wrn_s, rdn_s, addr_s, data_s} = sync2_r;

  assign sel_w = !csn_s && cs_s;
  assign wr_evt = sel_w && wrn_s && !wr_prev_r;
  assign ctl_wr = wr_evt && (addr_s == `PBCC_ADDR_CTRL);
  assign clk_grp = ctl_wr && !data_s[`PBCC_CTL_GROUP_BIT];
  assign out_grp = ctl_wr && data_s[`PBCC_CTL_GROUP_BIT];
  assign clk_rst_cmd = clk_grp && data_s[`PBCC_CTL_RST_BIT];
  assign adj_cmd = clk_grp && data_s[`PBCC_CTL_ADJ_BIT];
  assign int_rst_cmd = out_grp && data_s[`PBCC_CTL_RST_BIT];

  pbcc_timebase u_timebase (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .run_i(osc_s),
    .tick_o(tick)
  );

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_r <= `PBCC_RST_MODE;
      clk_stop_r <= 1'b0;
      pin_dis_r <= 1'b0;
      int_stop_r <= 1'b0;
    end
    else if (ctl_wr)
    begin
      mode_r <= data_s[7:4];
      if (!data_s[`PBCC_CTL_GROUP_BIT])
        clk_stop_r <= data_s[`PBCC_CTL_STOP_BIT];
      else
      begin
        pin_dis_r <= data_s[`PBCC_CTL_ADJ_BIT];
        int_stop_r <= data_s[`PBCC_CTL_STOP_BIT];
      end
    end
  end

  // Flag is only ever lowered by hardware; a stopped oscillator wins over a clock reset in the same cycle
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      oscillation_flag_r <= 1'b0;
    else if (!osc_s)
      oscillation_flag_r <= 1'b0;
    else if (clk_rst_cmd)
      oscillation_flag_r <= 1'b1;
  end

  // Sub-second divider; reset and adjust both restart the second
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      presc_r <= 15'h0000;
    else if (clk_rst_cmd || adj_cmd)
      presc_r <= 15'h0000;
    else if (tick && !clk_stop_r)
      presc_r <= presc_r + 15'h0001;
  end

  assign sec_tick = tick && !clk_stop_r && (presc_r == `PBCC_PRE_MAX);
  assign busy_w = !clk_stop_r && (presc_r > (`PBCC_PRE_MAX - `PBCC_BUSY_TICKS));
  assign leap_w = !leap_ctrl_r[1] && (leap_cnt_r == 2'b00);

  // Carry chain; adjust rounds to the nearest minute
  assign c_min = (sec_tick && sec_r == 8'h59) || (adj_cmd && sec_r >= 8'h30);
  assign c_hour = c_min && (min_r == 8'h59);
  assign c_day = c_hour && (hour_r[`PBCC_HOUR_FMT_BIT] ? (hour_r[6:0] == 7'h51) : (hour_r == 8'h23));
  assign c_mon = c_day && (day_r == month_days(mon_r, leap_w));
  assign c_year = c_mon && (mon_r == 8'h12);
  assign hour_inc_w = bcd_inc({2'b00, hour_r[5:0]});

  // A host write to a register wins over a count in the same cycle
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sec_r <= `PBCC_RST_SEC;
      min_r <= `PBCC_RST_MIN;
    end
    else
    begin
      if (wr_evt && addr_s == `PBCC_ADDR_SEC)
        sec_r <= data_s;
      else if (adj_cmd)
        sec_r <= 8'h00;
      else if (sec_tick)
        sec_r <= (sec_r == 8'h59) ? 8'h00 : bcd_inc(sec_r);
      if (wr_evt && addr_s == `PBCC_ADDR_MIN)
        min_r <= data_s;
      else if (c_min)
        min_r <= (min_r == 8'h59) ? 8'h00 : bcd_inc(min_r);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      hour_r <= `PBCC_RST_HOUR;
    else if (wr_evt && addr_s == `PBCC_ADDR_HOUR)
      hour_r <= {data_s[7], data_s[7] & data_s[6], data_s[5:0]};
    else if (c_hour)
    begin
      if (!hour_r[`PBCC_HOUR_FMT_BIT])
        hour_r <= (hour_r == 8'h23) ? 8'h00 : bcd_inc(hour_r);
      else if (hour_r[5:0] == 6'h12)
        hour_r <= {hour_r[7:6], 6'h01};
      else if (hour_r[5:0] == 6'h11)
        hour_r <= {1'b1, !hour_r[`PBCC_HOUR_PM_BIT], 6'h12};
      else
        hour_r <= {hour_r[7:6], hour_inc_w[5:0]};
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      leap_ctrl_r <= 2'b00;
      leap_cnt_r <= 2'b00;
      dow_r <= 4'h0;
    end
    else if (wr_evt && addr_s == `PBCC_ADDR_LEAP)
    begin
      leap_ctrl_r <= data_s[7:6];
      if (data_s[`PBCC_LEAP_WREN_BIT])
        leap_cnt_r <= data_s[5:4];
      dow_r <= data_s[3:0];
    end
    else
    begin
      if (c_year)
        leap_cnt_r <= leap_cnt_r + 2'b01;
      if (c_day)
        dow_r <= (dow_r == 4'h6) ? 4'h0 : dow_r + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      day_r <= `PBCC_RST_DAY;
      mon_r <= `PBCC_RST_MON;
      year_r <= `PBCC_RST_YEAR;
    end
    else
    begin
      if (wr_evt && addr_s == `PBCC_ADDR_DAY)
        day_r <= data_s;
      else if (c_day)
        day_r <= c_mon ? 8'h01 : bcd_inc(day_r);
      if (wr_evt && addr_s == `PBCC_ADDR_MON)
        mon_r <= data_s;
      else if (c_mon)
        mon_r <= c_year ? 8'h01 : bcd_inc(mon_r);
      if (wr_evt && addr_s == `PBCC_ADDR_YEAR)
        year_r <= data_s;
      else if (c_year)
        year_r <= bcd_inc(year_r);
    end
  end

  always_comb
  begin
    case (mode_r)
      `PBCC_MODE_INT2048: int_per_w = `PBCC_INT_P2048;
      `PBCC_MODE_INT1024: int_per_w = `PBCC_INT_P1024;
      `PBCC_MODE_INT256: int_per_w = `PBCC_INT_P256;
      `PBCC_MODE_INT64: int_per_w = `PBCC_INT_P64;
      `PBCC_MODE_INT1S: int_per_w = `PBCC_INT_P1S;
      `PBCC_MODE_INT10S: int_per_w = `PBCC_INT_P10S;
      `PBCC_MODE_INT60S: int_per_w = `PBCC_INT_P60S;
      default: int_per_w = `PBCC_INT_P2048;
    endcase
  end

  // Interval timer runs apart from the clock so it can serve as a watchdog
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      int_cnt_r <= 21'h000000;
    else if (int_rst_cmd)
      int_cnt_r <= 21'h000000;
    else if (tick && !int_stop_r)
      int_cnt_r <= (int_cnt_r >= int_per_w - 21'h000001) ? 21'h000000 : int_cnt_r + 21'h000001;
  end

  always_comb
  begin
    pin_flag_nxt = 1'b0;
    case (pbcc_mode_src(mode_r))
      PBCC_SRC_SQUARE:
      begin
        case (mode_r)
          `PBCC_MODE_SQ2048: pin_flag_nxt = presc_r[`PBCC_SQ2048_BIT];
          `PBCC_MODE_SQ1024: pin_flag_nxt = presc_r[`PBCC_SQ1024_BIT];
          `PBCC_MODE_SQ256: pin_flag_nxt = presc_r[`PBCC_SQ256_BIT];
          default: pin_flag_nxt = presc_r[`PBCC_SQ64_BIT];
        endcase
      end
      PBCC_SRC_INTERVAL: pin_flag_nxt = int_cnt_r < (int_per_w >> 1);
      PBCC_SRC_BUSY: pin_flag_nxt = busy_w;
      default: pin_flag_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pin_flag_r <= 1'b0;
    else
      pin_flag_r <= pin_flag_nxt;
  end

  // Enable gates only the pin, never the flag
  assign pulse_pin_o = 1'b0;
  assign pulse_pin_oe_n_o = !(pin_flag_r && !pin_dis_r);

  // Reads only sample the counters, never modify them
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_r <= 8'h00;
      oe_n_r <= 1'b1;
    end
    else
    begin
      oe_n_r <= !(sel_w && !rdn_s);
      case (addr_s)
        `PBCC_ADDR_SEC: data_r <= sec_r;
        `PBCC_ADDR_MIN: data_r <= min_r;
        `PBCC_ADDR_HOUR: data_r <= hour_r;
        `PBCC_ADDR_LEAP: data_r <= {leap_ctrl_r, leap_cnt_r, dow_r};
        `PBCC_ADDR_DAY: data_r <= day_r;
        `PBCC_ADDR_MON: data_r <= mon_r;
        `PBCC_ADDR_YEAR: data_r <= year_r;
        default: data_r <= {mode_r, 1'b0, pin_flag_r, oscillation_flag_r, busy_w};
      endcase
    end
  end
  assign data_o = data_r;
  assign data_oe_n_o = oe_n_r;

  property p_sel_read;
    !data_oe_n_o |-> $past(sel_w) && !$past(rdn_s);
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("bus driven without valid select and read");

  property p_sec_write;
    (wr_evt && addr_s == `PBCC_ADDR_SEC) |=> sec_r == $past(data_s);
  endproperty
  a_sec_write: assert property (p_sec_write) else $error("seconds write not stored");

  property p_pm_24h;
    !hour_r[`PBCC_HOUR_FMT_BIT] |-> !hour_r[`PBCC_HOUR_PM_BIT];
  endproperty
  a_pm_24h: assert property (p_pm_24h) else $error("PM bit set in 24-hour mode");

  property p_leap_lock;
    (wr_evt && addr_s == `PBCC_ADDR_LEAP && !data_s[`PBCC_LEAP_WREN_BIT] && !c_year) |=> $stable(leap_cnt_r);
  endproperty
  a_leap_lock: assert property (p_leap_lock) else $error("locked leap counter changed");

  property p_feb29;
    (c_day && !(wr_evt && addr_s == `PBCC_ADDR_DAY) && mon_r == 8'h02 && day_r == 8'h28 && leap_w) |=> day_r == 8'h29;
  endproperty
  a_feb29: assert property (p_feb29) else $error("leap February skipped day 29");

  property p_feb_noleap;
    (c_day && !(wr_evt && (addr_s == `PBCC_ADDR_DAY || addr_s == `PBCC_ADDR_MON)) && mon_r == 8'h02
      && day_r == 8'h28 && leap_ctrl_r == 2'b10) |=> day_r == 8'h01 && mon_r == 8'h03;
  endproperty
  a_feb_noleap: assert property (p_feb_noleap) else $error("February 28 not followed by March 1");

  property p_busy_pin;
    (mode_r == `PBCC_MODE_BUSY) ##1 (mode_r == `PBCC_MODE_BUSY) |-> pin_flag_r == $past(busy_w);
  endproperty
  a_busy_pin: assert property (p_busy_pin) else $error("pin does not follow busy");

  property p_pin_disable;
    pin_dis_r |-> pulse_pin_oe_n_o;
  endproperty
  a_pin_disable: assert property (p_pin_disable) else $error("disabled pin still driven");

  property p_flag_pin;
    !pulse_pin_oe_n_o |-> pin_flag_r;
  endproperty
  a_flag_pin: assert property (p_flag_pin) else $error("pin low without pin-state flag");

  property p_osc_set;
    $rose(oscillation_flag_r) |-> $past(clk_rst_cmd) && $past(osc_s);
  endproperty
  a_osc_set: assert property (p_osc_set) else $error("oscillation flag set without clock reset");

  property p_busy_before;
    sec_tick |-> busy_w ##1 !busy_w;
  endproperty
  a_busy_before: assert property (p_busy_before) else $error("second update outside busy window");

  property p_min_wrap;
    (c_min && !(wr_evt && addr_s == `PBCC_ADDR_MIN) && min_r == 8'h59) |=> min_r == 8'h00;
  endproperty
  a_min_wrap: assert property (p_min_wrap) else $error("minutes did not wrap at 59");

  property p_noon;
    (c_hour && !(wr_evt && addr_s == `PBCC_ADDR_HOUR) && hour_r == 8'h91) |=> hour_r == 8'hd2;
  endproperty
  a_noon: assert property (p_noon) else $error("11 AM not followed by noon D2");
endmodule : pbcc_top
`default_nettype wire

// file: logic/pbcc_params.svh
// Register map, field positions, reset values and timing counts of the calendar clock
`ifndef PBCC_PARAMS_SVH
`define PBCC_PARAMS_SVH

`define PBCC_ADDR_SEC 3'h0
`define PBCC_ADDR_MIN 3'h1
`define PBCC_ADDR_HOUR 3'h2
`define PBCC_ADDR_LEAP 3'h3
`define PBCC_ADDR_DAY 3'h4
`define PBCC_ADDR_MON 3'h5
`define PBCC_ADDR_YEAR 3'h6
`define PBCC_ADDR_CTRL 3'h7

`define PBCC_RST_SEC 8'h00
`define PBCC_RST_MIN 8'h00
`define PBCC_RST_HOUR 8'h00
`define PBCC_RST_DAY 8'h01
`define PBCC_RST_MON 8'h01
`define PBCC_RST_YEAR 8'h00
`define PBCC_RST_MODE 4'h0

`define PBCC_CTL_GROUP_BIT 3
`define PBCC_CTL_ADJ_BIT 2
`define PBCC_CTL_RST_BIT 1
`define PBCC_CTL_STOP_BIT 0
`define PBCC_HOUR_FMT_BIT 7
`define PBCC_HOUR_PM_BIT 6
`define PBCC_LEAP_WREN_BIT 6

`define PBCC_MODE_SQ2048 4'h0
`define PBCC_MODE_SQ1024 4'h1
`define PBCC_MODE_SQ256 4'h2
`define PBCC_MODE_SQ64 4'h3
`define PBCC_MODE_INT2048 4'h4
`define PBCC_MODE_INT1024 4'h5
`define PBCC_MODE_INT256 4'h6
`define PBCC_MODE_INT64 4'h7
`define PBCC_MODE_INT1S 4'h8
`define PBCC_MODE_INT10S 4'h9
`define PBCC_MODE_INT60S 4'ha
`define PBCC_MODE_BUSY 4'hb

// Reference clock and crystal rate in Hz
`define PBCC_REF_HZ 27'h5f5e100
`define PBCC_OSC_HZ 27'h0008000

// Prescaler bit whose toggling gives each square wave
`define PBCC_SQ2048_BIT 3
`define PBCC_SQ1024_BIT 4
`define PBCC_SQ256_BIT 6
`define PBCC_SQ64_BIT 8

`define PBCC_PRE_MAX 15'h7fff
`define PBCC_BUSY_TICKS 15'h0002

// Interval periods in crystal ticks
`define PBCC_INT_P2048 21'h000010
`define PBCC_INT_P1024 21'h000020
`define PBCC_INT_P256 21'h000080
`define PBCC_INT_P64 21'h000200
`define PBCC_INT_P1S 21'h008000
`define PBCC_INT_P10S 21'h050000
`define PBCC_INT_P60S 21'h1e0000

`endif

// file: logic/pbcc_pkg.sv
// Types shared by the calendar clock modules
`default_nettype none
package pbcc_pkg;
  typedef logic [7:0] pbcc_bcd_t;
  typedef enum logic [1:0] {PBCC_SRC_SQUARE, PBCC_SRC_INTERVAL, PBCC_SRC_BUSY, PBCC_SRC_TEST} pbcc_src_t;

  function automatic pbcc_src_t pbcc_mode_src(input logic [3:0] m);
    if (m < 4'h4)
      return PBCC_SRC_SQUARE;
    else if (m < 4'hb)
      return PBCC_SRC_INTERVAL;
    else if (m == 4'hb)
      return PBCC_SRC_BUSY;
    else
      return PBCC_SRC_TEST;
  endfunction : pbcc_mode_src
endpackage : pbcc_pkg
`default_nettype wire

// file: logic/pbcc_timebase.sv
// Fractional divider that makes a 32768 Hz tick from the reference clock
`default_nettype none
`include "pbcc_params.svh"
module pbcc_timebase
  import pbcc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic tick_o
);
  logic [26:0] acc_r;
  logic [26:0] sum_w;

  assign sum_w = acc_r + `PBCC_OSC_HZ;

  // Average rate is exact; single ticks jitter by one reference period
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc_r <= 27'h0000000;
      tick_o <= 1'b0;
    end
    else if (!run_i)
    begin
      tick_o <= 1'b0;
    end
    else if (sum_w >= `PBCC_REF_HZ)
    begin
      acc_r <= sum_w - `PBCC_REF_HZ;
      tick_o <= 1'b1;
    end
    else
    begin
      acc_r <= sum_w;
      tick_o <= 1'b0;
    end
  end
endmodule : pbcc_timebase
`default_nettype wire

// file: verif/pbcc_host.sv
// Host processor model that drives the calendar clock register port
`default_nettype none
module pbcc_host
  import pbcc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [7:0] dev_data_i,
  input wire logic dev_oe_n_i,
  output logic select_active_low_n_o,
  output logic select_active_high_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic [2:0] addr_o,
  output logic [7:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_drive = 1'b0;
  logic [7:0] host_data = 8'h00;
  logic [7:0] bus_last_r = 8'h5a;

  // A floating bus shows a changing pattern, so stale data never passes for a read
  assign bus_o = (dev_oe_n_i === 1'b0) ? dev_data_i : (host_drive ? host_data : ~bus_last_r);

  always @(posedge ref_clk_i)
    bus_last_r <= bus_o;

  initial
  begin
    select_active_low_n_o = 1'b1;
    select_active_high_o = 1'b0;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    addr_o = 3'h0;
  end

  task automatic release_bus;
    #1;
    select_active_low_n_o = 1'b1;
    select_active_high_o = 1'b0;
    host_drive = 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask : release_bus

  task automatic write_reg(input logic [2:0] a, input logic [7:0] d, input logic sel_n = 1'b0,
                           input logic sel = 1'b1);
    @(posedge ref_clk_i);
    #1;
    addr_o = a;
    host_data = d;
    host_drive = 1'b1;
    select_active_low_n_o = sel_n;
    select_active_high_o = sel;
    wr_n_o = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1;
    wr_n_o = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    release_bus();
  endtask : write_reg

  // Reads only look at the bus; the device counters are left alone
  task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
    int n;
    @(posedge ref_clk_i);
    #1;
    addr_o = a;
    select_active_low_n_o = 1'b0;
    select_active_high_o = 1'b1;
    rd_n_o = 1'b0;
    n = 0;
    while (dev_oe_n_i !== 1'b0 && n < 10)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    repeat (2) @(posedge ref_clk_i);
    d = (dev_oe_n_i === 1'b0) ? bus_o : 8'hxx;
    #1;
    rd_n_o = 1'b1;
    n = 0;
    while (dev_oe_n_i !== 1'b1 && n < 8)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    // A device that keeps driving spoils the value handed back
    if (dev_oe_n_i !== 1'b1)
      d = 8'hxx;
    release_bus();
  endtask : read_reg
endmodule : pbcc_host
`default_nettype wire

// file: verif/pbcc_top_tb.sv
// Self-checking bench for the calendar clock core
`default_nettype none
`include "pbcc_params.svh"
`define PBCC_CHK(what, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end
module pbcc_top_tb
  import pbcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TIMEOUT_CYCLES = 90000;
  typedef struct packed {logic [2:0] a; logic [7:0] wr; logic [7:0] exp;} pbcc_row_t;
  typedef struct packed {logic [7:0] leap; logic [7:0] hour; logic [7:0] day; logic [7:0] e_hour;
                         logic [7:0] e_day; logic [7:0] e_mon;} pbcc_adj_t;
  pbcc_row_t rows [9] = '{'{3'h0, 8'h59, 8'h59}, '{3'h1, 8'h45, 8'h45}, '{3'h2, 8'h63, 8'h23},
                          '{3'h2, 8'hd2, 8'hd2}, '{3'h3, 8'h76, 8'h76}, '{3'h3, 8'h86, 8'hb6},
                          '{3'h4, 8'h31, 8'h31}, '{3'h5, 8'h12, 8'h12}, '{3'h6, 8'h99, 8'h99}};
  // Minute 59 and second 45 are set before each adjust, so every case carries over the hour
  pbcc_adj_t adj [4] = '{'{8'h80, 8'h23, 8'h28, 8'h00, 8'h01, 8'h03},
                         '{8'h40, 8'h23, 8'h28, 8'h00, 8'h29, 8'h02},
                         '{8'h40, 8'hd1, 8'h10, 8'h92, 8'h11, 8'h02},
                         '{8'h40, 8'h91, 8'h10, 8'hd2, 8'h10, 8'h02}};
  logic [7:0] rst_exp [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic osc_running_i = 1'b1;
  logic select_active_low_n;
  logic select_active_high;
  logic wr_n;
  logic rd_n;
  logic [2:0] addr;
  logic [7:0] bus;
  logic [7:0] data_o;
  logic data_oe_n_o;
  logic pulse_pin_o;
  logic pulse_pin_oe_n_o;
  logic [7:0] rd;
  logic ok;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  pbcc_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .select_active_low_n_i(select_active_low_n),
    .select_active_high_i(select_active_high), .wr_n_i(wr_n), .rd_n_i(rd_n), .addr_i(addr), .data_i(bus),
    .osc_running_i(osc_running_i), .data_o(data_o), .data_oe_n_o(data_oe_n_o), .pulse_pin_o(pulse_pin_o),
    .pulse_pin_oe_n_o(pulse_pin_oe_n_o));

  pbcc_host host (.ref_clk_i(ref_clk_i), .dev_data_i(data_o), .dev_oe_n_i(data_oe_n_o),
    .select_active_low_n_o(select_active_low_n), .select_active_high_o(select_active_high), .wr_n_o(wr_n),
    .rd_n_o(rd_n), .addr_o(addr), .bus_o(bus));

  task automatic results;
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic wait_pin(input logic lvl, output logic hit);
    int n;
    n = 0;
    hit = 1'b0;
    while (n < 50000 && !hit)
    begin
      @(posedge ref_clk_i);
      hit = (pulse_pin_oe_n_o === lvl);
      n++;
    end
  endtask : wait_pin

  task automatic set_osc(input logic v);
    @(posedge ref_clk_i);
    #1;
    osc_running_i = v;
    repeat (10) @(posedge ref_clk_i);
  endtask : set_osc

  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES)
    begin
      bad_count++;
      $display("mismatch run length expected %0d seen %0d", TIMEOUT_CYCLES - 1, cycles);
      results();
    end
  end

  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    foreach (rows[i])
    begin
      host.write_reg(rows[i].a, rows[i].wr);
      host.read_reg(rows[i].a, rd);
      `PBCC_CHK("register readback", rows[i].exp, rd)
    end
    #1;
    rst_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    for (int r = 0; r < 7; r++)
    begin
      host.read_reg(r[2:0], rd);
      `PBCC_CHK("value after reset", rst_exp[r], rd)
    end
    host.read_reg(`PBCC_ADDR_CTRL, rd);
    `PBCC_CHK("oscillation flag after power", 1'b0, rd[1])
    host.write_reg(`PBCC_ADDR_CTRL, 8'h02);
    host.read_reg(`PBCC_ADDR_CTRL, rd);
    `PBCC_CHK("oscillation flag after clock reset", 1'b1, rd[1])
    set_osc(1'b0);
    host.write_reg(`PBCC_ADDR_CTRL, 8'h02);
    set_osc(1'b1);
    host.read_reg(`PBCC_ADDR_CTRL, rd);
    `PBCC_CHK("oscillation flag latched", 1'b0, rd[1])
    host.write_reg(`PBCC_ADDR_CTRL, 8'h02);
    host.read_reg(`PBCC_ADDR_CTRL, rd);
    `PBCC_CHK("oscillation flag rearmed", 1'b1, rd[1])
    foreach (adj[i])
    begin
      host.write_reg(`PBCC_ADDR_LEAP, adj[i].leap);
      host.write_reg(`PBCC_ADDR_MON, 8'h02);
      host.write_reg(`PBCC_ADDR_DAY, adj[i].day);
      host.write_reg(`PBCC_ADDR_HOUR, adj[i].hour);
      host.write_reg(`PBCC_ADDR_MIN, 8'h59);
      host.write_reg(`PBCC_ADDR_SEC, 8'h45);
      host.write_reg(`PBCC_ADDR_CTRL, 8'h04);
      host.read_reg(`PBCC_ADDR_SEC, rd);
      `PBCC_CHK("seconds after adjust", 8'h00, rd)
      host.read_reg(`PBCC_ADDR_MIN, rd);
      `PBCC_CHK("minutes after adjust", 8'h00, rd)
      host.read_reg(`PBCC_ADDR_HOUR, rd);
      `PBCC_CHK("hour after carry", adj[i].e_hour, rd)
      host.read_reg(`PBCC_ADDR_DAY, rd);
      `PBCC_CHK("day after carry", adj[i].e_day, rd)
      host.read_reg(`PBCC_ADDR_MON, rd);
      `PBCC_CHK("month after carry", adj[i].e_mon, rd)
    end
    host.write_reg(`PBCC_ADDR_SEC, 8'h33, 1'b1, 1'b1);
    host.write_reg(`PBCC_ADDR_SEC, 8'h33, 1'b0, 1'b0);
    host.read_reg(`PBCC_ADDR_SEC, rd);
    `PBCC_CHK("write with select inactive", 8'h00, rd)
    for (int m = 0; m < 16; m++)
    begin
      host.write_reg(`PBCC_ADDR_CTRL, {m[3:0], 4'h8});
      host.read_reg(`PBCC_ADDR_CTRL, rd);
      `PBCC_CHK("mode readback", m[3:0], rd[7:4])
      if (m >= 11)
        `PBCC_CHK("pin idle in busy or test mode", 1'b1, pulse_pin_oe_n_o)
    end
    // Interval reset restarts the period in its low half
    host.write_reg(`PBCC_ADDR_CTRL, 8'h4a);
    `PBCC_CHK("interval reset pulls pin low", 1'b0, pulse_pin_oe_n_o)
    host.write_reg(`PBCC_ADDR_CTRL, 8'h08);
    wait_pin(1'b1, ok);
    wait_pin(1'b0, ok);
    `PBCC_CHK("square wave pulls pin low", 1'b1, ok)
    `PBCC_CHK("open drain level", 1'b0, pulse_pin_o)
    host.write_reg(`PBCC_ADDR_CTRL, 8'h0c);
    `PBCC_CHK("pin released when disabled", 1'b1, pulse_pin_oe_n_o)
    host.read_reg(`PBCC_ADDR_CTRL, rd);
    `PBCC_CHK("pin flag while disabled", 1'b1, rd[2])
    `PBCC_CHK("busy flag outside update", 1'b0, rd[0])
    ok = 1'b1;
    repeat (5000)
    begin
      @(posedge ref_clk_i);
      ok = ok & (pulse_pin_oe_n_o === 1'b1);
    end
    `PBCC_CHK("pin stays released", 1'b1, ok)
    results();
  end
endmodule : pbcc_top_tb
`default_nettype wire
